// ===== design/tfi_core.sv
`timescale 1ns/1ns
`include "tfi_consts.svh"

module tfi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire              wp_wrap = (wp_r == AW'(DEPTH-1));
    wire              rp_wrap = (rp_r == AW'(DEPTH-1));
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_wrap ? '0 : wp_r + 1'b1;
            if (pop) rp_r <= rp_wrap ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem_r[wp_r] <= in_data;
    end
endmodule

// Smaller of two sizes
module tfi_min #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    output logic      [W-1:0] y
);
    wire a_less = (a < b);
    assign y = a_less ? a : b;
endmodule

// Two-flop synchroniser for words that change one bit at a time
module tfi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule

module tfi_core #(
    parameter int NCH   = `TFI_NUM_CHAN,
    parameter int DEPTH = `TFI_FIFO_DEPTH,
    parameter int TB_LAG = `TFI_TB_LAG
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              SREQ_VALID,
    input  wire tfi_pkg::tfi_sreq_t SREQ,
    output logic                   SREQ_READY,
    output logic                   CTRL_OPEN,
    output tfi_pkg::tfi_sreq_t     OPEN_REQ,
    output logic                   OPEN_VALID,
    output logic [15:0]            CTRL_UDP_PORT,
    input  wire logic              OPEN_ACK,
    input  wire tfi_pkg::tfi_srep_t OPEN_REP,
    output logic                   DISC_VALID,
    output logic [2:0]             DISC_CHAN,
    output logic [NCH-1:0]         SESS_ACTIVE,
    input  wire logic              CLOSE_VALID,
    input  wire logic [2:0]        CLOSE_CHAN,
    input  wire logic              PKT_VALID,
    output logic                   PKT_READY,
    input  wire tfi_pkg::tfi_pkt_t PKT,
    output logic                   PKT_DROP,
    output logic                   TX_VALID,
    input  wire logic              TX_READY,
    output tfi_pkg::tfi_tx_t       TX,
    input  wire logic [31:0]       TIME_REF,
    output logic [31:0]            TIME_BASE
);
    import tfi_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DONE} tfi_state_t;
    tfi_state_t   st_r;
    tfi_sreq_t    req_r;
    logic [NCH-1:0] act_r;
    logic [31:0]  sid_r;
    logic [31:0]  sid_ctr_r;
    tfi_addr_t    addr_r [NCH];
    logic [15:0]  mtu_r  [NCH];
    logic [15:0]  seq_r  [NCH];
    logic         open_v_r;
    logic         disc_r;
    logic [2:0]   disc_ch_r;
    logic         ack_sync;
    logic [31:0]  tref_sync;
    logic [31:0]  tref_bin;
    logic [31:0]  tb_r;
    logic [15:0]  adv_mtu;
    logic [15:0]  sess_mtu;
    logic         ack_d_r;
    logic         ctrl_r;
    tfi_tx_t      tx_r;
    logic         tx_v_r;
    logic         drop_r;

    wire ack_rise = ack_sync && !ack_d_r;

    tfi_min #(.W(16)) u_adv_min (
        .a (SREQ.local_mtu),
        .b (SREQ.iface_mtu),
        .y (adv_mtu)
    );

    wire req_busy = act_r[SREQ.chan];
    wire take_req = (st_r == S_IDLE) && SREQ_VALID && !req_busy;
    wire rep_fits = (OPEN_REP.remote_mtu >= `TFI_MIN_MTU);

    tfi_min #(.W(16)) u_sess_min (
        .a (OPEN_REP.remote_mtu),
        .b (req_r.local_mtu),
        .y (sess_mtu)
    );

    wire rep_ok = OPEN_REP.ok && rep_fits;
    wire open_done = (st_r == S_WAIT) && ack_rise && rep_ok;

    assign SREQ_READY    = (st_r == S_IDLE) && !req_busy;
    assign OPEN_VALID    = open_v_r;
    assign OPEN_REQ      = req_r;
    assign CTRL_OPEN     = ctrl_r;
    assign CTRL_UDP_PORT = `TFI_CTRL_PORT;
    assign DISC_VALID    = disc_r;
    assign DISC_CHAN     = disc_ch_r;
    assign SESS_ACTIVE   = act_r;

    tfi_sync #(.W(1)) u_ack_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .d     (OPEN_ACK),
        .q     (ack_sync)
    );

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_d_r <= 1'b0;
        end else begin
            ack_d_r <= ack_sync;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r      <= S_IDLE;
            req_r     <= '0;
            open_v_r  <= 1'b0;
            disc_r    <= 1'b0;
            disc_ch_r <= '0;
            ctrl_r    <= 1'b0;
            sid_ctr_r <= 32'h00000001;
            act_r     <= '0;
        end else begin
            disc_r <= 1'b0;
            if (CLOSE_VALID) act_r[CLOSE_CHAN] <= 1'b0;
            unique case (st_r)
                S_IDLE: if (take_req) begin
                    req_r           <= SREQ;
                    req_r.local_mtu <= adv_mtu;
                    open_v_r        <= 1'b1;
                    ctrl_r          <= 1'b1;
                    st_r            <= S_WAIT;
                end
                S_WAIT: if (ack_rise) begin
                    open_v_r <= 1'b0;
                    if (rep_ok) begin
                        act_r[req_r.chan] <= 1'b1;
                        sid_ctr_r <= sid_ctr_r + 32'h00000001;
                    end else begin
                        disc_r    <= 1'b1;
                        disc_ch_r <= req_r.chan;
                    end
                    st_r <= S_DONE;
                end
                S_DONE: if (!ack_sync) st_r <= S_IDLE;
                default: st_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (open_done) begin
            addr_r[req_r.chan].udp_port   <= OPEN_REP.udp_port;
            addr_r[req_r.chan].session_id <= OPEN_REP.remote_sid;
            addr_r[req_r.chan].flow_id    <= OPEN_REP.flow_id;
            mtu_r[req_r.chan]             <= sess_mtu;
        end
    end

    assign sid_r = sid_ctr_r;

    // Reference time arrives as a gray word from the timing client
    tfi_sync #(.W(32)) u_tref_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .d     (TIME_REF),
        .q     (tref_sync)
    );

    for (genvar gi = 0; gi < 32; gi++) begin : g_gray
        assign tref_bin[gi] = ^tref_sync[31:gi];
    end

    // Local timebase trails the reference by the sync delay, one register cycle and TB_LAG
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tb_r <= '0;
        end else begin
            tb_r <= tref_bin - 32'(TB_LAG);
        end
    end

    assign TIME_BASE = tb_r;

    logic       f_v;
    logic       f_rdy;
    tfi_pkt_t   f_d;
    tfi_fifo #(.WIDTH($bits(tfi_pkt_t)), .DEPTH(DEPTH)) u_fifo (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (PKT_VALID),
        .in_ready  (PKT_READY),
        .in_data   (PKT),
        .out_valid (f_v),
        .out_ready (f_rdy),
        .out_data  (f_d)
    );

    wire pkt_ok  = act_r[f_d.chan] && (f_d.len <= mtu_r[f_d.chan]);
    wire tx_free = !tx_v_r || TX_READY;
    assign f_rdy = tx_free;
    wire send = f_v && f_rdy && pkt_ok;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NCH; i++) seq_r[i] <= '0;
            tx_v_r <= 1'b0;
            tx_r   <= '0;
            drop_r <= 1'b0;
        end else begin
            drop_r <= f_v && f_rdy && !pkt_ok;
            if (st_r == S_WAIT && ack_rise && rep_ok)
                seq_r[req_r.chan] <= '0;
            if (tx_free) tx_v_r <= send;
            if (send) begin
                tx_r.addr <= addr_r[f_d.chan];
                tx_r.seq  <= seq_r[f_d.chan];
                tx_r.df   <= 1'b1;
                tx_r.len  <= f_d.len;
                tx_r.data <= f_d.data;
                seq_r[f_d.chan] <= seq_r[f_d.chan] + 16'h0001;
            end
        end
    end

    assign TX_VALID = tx_v_r;
    assign TX       = tx_r;
    assign PKT_DROP = drop_r;
endmodule

// ===== design/tfi_consts.svh
`ifndef TFI_CONSTS_SVH
`define TFI_CONSTS_SVH
`define TFI_MIN_MTU      16'h05DC
`define TFI_CTRL_PORT    16'h06A5
`define TFI_TB_LAG_MAX   8'h64
`define TFI_TB_LAG       8'h00
`define TFI_NUM_CHAN     8
`define TFI_FIFO_DEPTH   16
`endif

// ===== design/tfi_pkg.sv
package tfi_pkg;
    typedef struct packed {
        logic [15:0] udp_port;
        logic [31:0] session_id;
        logic [7:0]  flow_id;
    } tfi_addr_t;
    typedef struct packed {
        logic [2:0]  chan;
        logic [15:0] local_mtu;
        logic [15:0] iface_mtu;
    } tfi_sreq_t;
    typedef struct packed {
        logic        ok;
        logic [31:0] remote_sid;
        logic [15:0] remote_mtu;
        logic [7:0]  flow_id;
        logic [15:0] udp_port;
    } tfi_srep_t;
    typedef struct packed {
        logic [2:0]  chan;
        logic [15:0] len;
        logic [31:0] data;
    } tfi_pkt_t;
    typedef struct packed {
        tfi_addr_t   addr;
        logic [15:0] seq;
        logic        df;
        logic [15:0] len;
        logic [31:0] data;
    } tfi_tx_t;
endpackage

// ===== verification/tfi_core_sva.sv
`timescale 1ns/1ns
module tfi_core_sva
    import tfi_pkg::*;
#(parameter int NCH = 8) (
    input wire logic               CLK,
    input wire logic               RST_N,
    input wire logic               SREQ_VALID,
    input wire tfi_pkg::tfi_sreq_t SREQ,
    input wire logic               SREQ_READY,
    input wire logic               CTRL_OPEN,
    input wire tfi_pkg::tfi_sreq_t OPEN_REQ,
    input wire logic               OPEN_VALID,
    input wire logic [15:0]        CTRL_UDP_PORT,
    input wire logic               DISC_VALID,
    input wire logic [NCH-1:0]     SESS_ACTIVE,
    input wire logic               TX_VALID,
    input wire logic               TX_READY,
    input wire tfi_pkg::tfi_tx_t   TX
);
    wire logic [15:0] req_min = SREQ.local_mtu < SREQ.iface_mtu ?
                                SREQ.local_mtu : SREQ.iface_mtu;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    min_mtu_a:
        assert property (SREQ_VALID && SREQ_READY |=> OPEN_VALID
            && OPEN_REQ.local_mtu == $past(req_min)) else $error("mtu");
    req_hold_a:
        assert property (OPEN_VALID |-> !SREQ_READY) else $error("rdy");
    busy_chan_a:
        assert property (SESS_ACTIVE[SREQ.chan] |-> !SREQ_READY)
            else $error("busy");
    df_flag_a:
        assert property (TX_VALID |-> TX.df) else $error("df");
    tx_hold_a:
        assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX))
            else $error("tx");
    one_ctrl_a:
        assert property (CTRL_OPEN |=> CTRL_OPEN && CTRL_UDP_PORT == 16'h06A5)
            else $error("ctrl");
    disc_once_a:
        assert property (DISC_VALID |=> !DISC_VALID) else $error("disc");
    disc_idle_a:
        assert property (DISC_VALID |-> !OPEN_VALID) else $error("open");
endmodule
bind tfi_core tfi_core_sva #(.NCH(NCH)) i_sva (.*);

// ===== verification/tfi_modem_model.sv
`timescale 1ns/1ns
module tfi_modem_model
    import tfi_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               open_valid,
    input  wire tfi_pkg::tfi_sreq_t open_req,
    output tfi_pkg::tfi_srep_t      open_rep,
    output logic                    open_ack,
    input  wire logic               refuse,
    input  wire logic [15:0]        own_mtu,
    input  wire logic               stall,
    input  wire logic               tx_valid,
    input  wire tfi_pkg::tfi_tx_t   tx,
    output logic                    tx_ready,
    output int                      fwd_cnt,
    output int                      err_cnt
);
    logic [7:0]  up, nf;
    logic [15:0] gap;
    logic [15:0] exp_seq [256];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {open_ack, tx_ready, up, nf, open_rep} <= '0;
            {fwd_cnt, err_cnt} <= '0;
            foreach (exp_seq[i]) exp_seq[i] <= 16'h0000;
        end else begin
            tx_ready <= !stall;
            if (open_valid && !open_ack) begin
                open_ack <= 1'b1;
                open_rep <= '{!refuse && !up[open_req.chan],
                    {24'h000000, nf}, own_mtu, nf, 16'hC000 | nf};
                up[open_req.chan] <= up[open_req.chan] |
                    (!refuse && own_mtu >= 16'h05DC);
                nf <= nf + 8'h01;
            end else if (!open_valid) begin
                open_ack <= 1'b0;
                open_rep <= ~open_rep;
            end
            if (tx_valid && tx_ready) begin
                gap = tx.seq - exp_seq[tx.addr.flow_id];
                if (gap[15] || !tx.df || tx.len > own_mtu) begin
                    err_cnt <= err_cnt + 1;
                end else begin
                    err_cnt <= err_cnt + int'(gap != 16'h0000);
                    fwd_cnt <= fwd_cnt + 1;
                    exp_seq[tx.addr.flow_id] <= tx.seq + 16'h0001;
                end
            end
        end
    end
endmodule

// ===== verification/tfi_tb_top.sv
`timescale 1ns/1ns
module tunnel_flow_ingress_sequencer_tb_top;
    import tfi_pkg::*;
    logic        CLK, RST_N, SREQ_VALID, SREQ_READY, CTRL_OPEN, OPEN_VALID;
    logic        OPEN_ACK, DISC_VALID, CLOSE_VALID, PKT_VALID, PKT_READY;
    logic        PKT_DROP, TX_VALID, TX_READY, refuse, stall;
    logic [2:0]  DISC_CHAN, CLOSE_CHAN;
    logic [7:0]  SESS_ACTIVE;
    logic [15:0] CTRL_UDP_PORT, own_mtu;
    tfi_sreq_t   SREQ, OPEN_REQ;
    tfi_srep_t   OPEN_REP;
    tfi_pkt_t    PKT;
    tfi_tx_t     TX;
    int          bad_count, n_tests, fwd_cnt, err_cnt, drops;
    logic [31:0] TIME_REF, TIME_BASE, tref_cnt;
    tfi_core i_dut (.*);
    tfi_modem_model i_far (.clk(CLK), .rst_n(RST_N), .open_valid(OPEN_VALID),
        .open_req(OPEN_REQ), .open_rep(OPEN_REP), .open_ack(OPEN_ACK),
        .refuse(refuse), .own_mtu(own_mtu), .stall(stall), .tx(TX),
        .tx_valid(TX_VALID), .tx_ready(TX_READY), .fwd_cnt(fwd_cnt),
        .err_cnt(err_cnt));
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    always @(posedge CLK) if (PKT_DROP === 1'b1) drops++;
    always @(posedge CLK) begin
        tref_cnt <= RST_N ? tref_cnt + 32'h00000001 : 32'h00000000;
        TIME_REF <= tref_cnt ^ (tref_cnt >> 1);
    end
    task automatic t_time();
        logic [31:0] lag;
        repeat (8) @(posedge CLK);
        #1;
        lag = tref_cnt - TIME_BASE;
        ck(TIME_BASE != 32'h00000000 && lag <= 32'h00000064, "time");
        $display("time done");
    endtask
    task automatic ck(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_open(input logic [2:0] ch, input logic [15:0] lm, im, rm,
                          input logic rf, input logic ok);
        int k;
        bit d;
        {k, d} = '0;
        @(posedge CLK);
        {refuse, own_mtu, SREQ_VALID} <= {rf, rm, 1'b1};
        SREQ <= '{ch, lm, im};
        @(posedge CLK);
        SREQ_VALID <= 1'b0;
        #1;
        ck(OPEN_VALID === 1'b1 && OPEN_REQ.local_mtu === (lm < im ? lm : im)
           && CTRL_OPEN === 1'b1 && CTRL_UDP_PORT === 16'h06A5, "req");
        while (OPEN_VALID === 1'b1 && k < 40) begin
            @(posedge CLK);
            #1;
            k++;
            d |= DISC_VALID === 1'b1;
        end
        ck(SESS_ACTIVE[ch] === ok && d === !ok, "session");
        repeat (4) @(posedge CLK);
        $display("open %0d done", ch);
    endtask
    task automatic t_busy();
        @(posedge CLK);
        SREQ_VALID <= 1'b1;
        SREQ <= '{3'h0, 16'h05DC, 16'h05DC};
        repeat (3) @(posedge CLK);
        SREQ_VALID <= 1'b0;
        #1;
        ck(SREQ_READY === 1'b0 && OPEN_VALID === 1'b0, "busy");
        $display("busy done");
    endtask
    task automatic t_fill(input logic [2:0] ch);
        int n, f, e, k;
        {n, k, f, e} = {32'h0, 32'h0, fwd_cnt, err_cnt};
        @(posedge CLK);
        {stall, PKT_VALID} <= 2'b11;
        PKT <= '{ch, 16'h0040, 32'h00000000};
        #1;
        while (PKT_READY === 1'b1 && n < 40) begin
            @(posedge CLK);
            n++;
            PKT.data <= n;
            #1;
        end
        @(posedge CLK);
        {stall, PKT_VALID} <= 2'b00;
        while (fwd_cnt - f != n && k < 99) begin
            @(posedge CLK);
            k++;
        end
        ck(n >= 16 && fwd_cnt - f == n && err_cnt == e, "stream");
        $display("stream %0d done", ch);
    endtask
    task automatic t_drop();
        int f;
        f = drops;
        @(posedge CLK);
        {CLOSE_VALID, CLOSE_CHAN, PKT_VALID} <= 5'b10011;
        PKT <= '{3'h1, 16'h0040, 32'h00000000};
        @(posedge CLK);
        CLOSE_VALID <= 1'b0;
        PKT <= '{3'h0, 16'h0800, 32'h00000000};
        @(posedge CLK);
        PKT_VALID <= 1'b0;
        repeat (10) @(posedge CLK);
        ck(drops - f == 2 && SESS_ACTIVE[1] === 1'b0, "drop");
        $display("drop done");
    endtask
    initial begin
        {RST_N, SREQ_VALID, CLOSE_VALID, PKT_VALID, refuse, stall} = '0;
        {SREQ, PKT, CLOSE_CHAN, own_mtu} = '0;
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        t_open(3'h0, 16'h0800, 16'h05DC, 16'h05DC, 1'b0, 1'b1);
        t_open(3'h1, 16'h05DC, 16'h0900, 16'h0600, 1'b0, 1'b1);
        t_busy();
        t_open(3'h2, 16'h05DC, 16'h05DC, 16'h05DB, 1'b0, 1'b0);
        t_open(3'h3, 16'h05DC, 16'h05DC, 16'h05DC, 1'b1, 1'b0);
        t_fill(3'h0);
        t_fill(3'h1);
        t_drop();
        t_time();
        complete_run();
    end
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end
endmodule
